// ---- bench/dcfpf_checker.sv ----
`timescale 1ns/1ps
module dcfpf_checker
    import dcfpf_pkg::*;
#(
    parameter int DEPTH_LOG2 = DEPTH_LOG2_DEF
) (
    // controls
    input wire logic              clk_sys_i,
    input wire logic              rst_n_i,
    input wire logic              full_init_n_i,
    input wire logic              soft_init_n_i,
    input wire logic              replay_n_i,
    input wire logic              mode_sel_serial_in_i,
    input wire logic              offset_access_n_i,
    input wire logic              ser_load_en_n_i,
    input wire logic              write_en_n_i,
    input wire logic              read_en_n_i,
    input wire logic              out_en_n_i,
    // outputs
    input wire logic [DATA_W-1:0] data_out_o,
    input wire logic              data_out_oe_o,
    input wire logic              empty_n_o,
    input wire logic              full_n_o,
    input wire logic              half_n_o,
    input wire logic              almost_empty_n_o,
    input wire logic              almost_full_n_o,
    input wire logic              power_down_o
);
    logic ft_r;
    logic run;
    // mode copy, since the checker sees only pins
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) ft_r <= 1'b0;
        else if (!full_init_n_i) ft_r <= mode_sel_serial_in_i;
    end
    assign run = full_init_n_i && soft_init_n_i && replay_n_i;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_quiet;
        write_en_n_i && read_en_n_i && run && ser_load_en_n_i && offset_access_n_i;
    endsequence
    sequence s_wr_empty;
        !ft_r && !empty_n_o && !write_en_n_i && offset_access_n_i && read_en_n_i && run;
    endsequence
    property p_idle; s_quiet [*4] |=> power_down_o; endproperty
    property p_wake; (!write_en_n_i || !read_en_n_i || !replay_n_i) |=> !power_down_o; endproperty
    property p_wr; s_wr_empty |-> ##[1:3] empty_n_o; endproperty
    property p_init;
        $rose(full_init_n_i) |-> empty_n_o == ft_r && full_n_o == !ft_r && half_n_o && !almost_empty_n_o;
    endproperty
    property p_soft; $rose(soft_init_n_i) |-> empty_n_o == ft_r && !almost_empty_n_o && almost_full_n_o; endproperty
    property p_full; !ft_r && !full_n_o |-> !half_n_o && !almost_full_n_o && empty_n_o; endproperty
    property p_hold; !ft_r && read_en_n_i && run |=> $stable(data_out_o); endproperty
    property p_replay; !ft_r && !replay_n_i && full_init_n_i && soft_init_n_i |=> !empty_n_o; endproperty
    property p_oe; $fell(out_en_n_i) |=> data_out_oe_o ##1 (data_out_oe_o == !$past(out_en_n_i)); endproperty
    a_idle: assert property (p_idle) else $error("no power down when idle");
    a_wake: assert property (p_wake) else $error("power down during activity");
    a_wr: assert property (p_wr) else $error("write did not clear empty");
    a_init: assert property (p_init) else $error("flags wrong after full init");
    a_soft: assert property (p_soft) else $error("flags wrong after soft init");
    a_full: assert property (p_full) else $error("full without half and almost full");
    a_hold: assert property (p_hold) else $error("output moved without read");
    a_replay: assert property (p_replay) else $error("replay did not force empty");
    a_oe: assert property (p_oe) else $error("output enable not followed");
endmodule : dcfpf_checker

bind dcfpf_top dcfpf_checker #(.DEPTH_LOG2(DEPTH_LOG2)) i_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .full_init_n_i(full_init_n_i),
    .soft_init_n_i(soft_init_n_i), .replay_n_i(replay_n_i), .mode_sel_serial_in_i(mode_sel_serial_in_i),
    .offset_access_n_i(offset_access_n_i), .ser_load_en_n_i(ser_load_en_n_i), .write_en_n_i(write_en_n_i),
    .read_en_n_i(read_en_n_i), .out_en_n_i(out_en_n_i), .data_out_o(data_out_o), .data_out_oe_o(data_out_oe_o),
    .empty_n_o(empty_n_o), .full_n_o(full_n_o), .half_n_o(half_n_o), .almost_empty_n_o(almost_empty_n_o),
    .almost_full_n_o(almost_full_n_o), .power_down_o(power_down_o));

// ---- bench/dcfpf_producer.sv ----
`timescale 1ns/1ps
module dcfpf_producer
    import dcfpf_pkg::*;
(
    // control from bench
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              go_i,
    input  wire logic              gap_i,
    input  wire logic [DATA_W-1:0] base_i,
    input  wire logic [15:0]       num_i,
    // write port
    output logic                   write_en_n_o,
    output logic [DATA_W-1:0]      data_o,
    output logic                   busy_o
);
    logic [15:0]       left;
    logic [DATA_W-1:0] nxt;
    logic              slot = 1'b0;
    // gap mode writes every other cycle, a slow producer
    always @(posedge clk_sys_i) begin
        slot <= ~slot;
        if (!rst_n_i) begin
            left <= 16'h0;
            write_en_n_o <= 1'b1;
            data_o <= '0;
        end else if (go_i) begin
            left <= num_i;
            nxt <= base_i;
        end else if (left != 16'h0 && (!gap_i || slot)) begin
            write_en_n_o <= 1'b0;
            data_o <= nxt;
            nxt <= nxt + 1'b1;
            left <= left - 1'b1;
        end else begin
            write_en_n_o <= 1'b1;
            // released bus inverts the old word; only a go cycle keeps it
            data_o <= ~data_o;
        end
    end
    assign busy_o = left != 16'h0 || !write_en_n_o;
endmodule : dcfpf_producer

// ---- bench/dcfpf_top_bench.sv ----
`timescale 1ns/1ps
module dcfpf_top_bench;
    import dcfpf_pkg::*;
    localparam int AW = 11;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, full_init_n = 1'b0, soft_init_n = 1'b1, replay_n = 1'b1;
    logic mode_sel = 1'b0, oa_n = 1'b1, ser_n = 1'b1, read_en_n = 1'b1, out_en_n = 1'b1, go = 1'b0, gap = 1'b0;
    logic write_en_n, busy, oe, empty_n, full_n, half_n, ae_n, af_n, pd;
    logic [DATA_W-1:0] data_in, data_out, base = '0;
    logic [15:0] num = 16'h0;
    wire logic [4:0] flags = {empty_n, full_n, half_n, ae_n, af_n};
    int miscompares = 0;
    int checks_done = 0;
    dcfpf_top #(.DEPTH_LOG2(AW)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .full_init_n_i(full_init_n),
        .soft_init_n_i(soft_init_n), .replay_n_i(replay_n), .mode_sel_serial_in_i(mode_sel),
        .offset_access_n_i(oa_n), .ser_load_en_n_i(ser_n), .write_en_n_i(write_en_n), .data_in_i(data_in),
        .read_en_n_i(read_en_n), .out_en_n_i(out_en_n), .data_out_o(data_out), .data_out_oe_o(oe),
        .empty_n_o(empty_n), .full_n_o(full_n), .half_n_o(half_n), .almost_empty_n_o(ae_n),
        .almost_full_n_o(af_n), .power_down_o(pd));
    dcfpf_producer i_prod (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(go), .gap_i(gap), .base_i(base),
        .num_i(num), .write_en_n_o(write_en_n), .data_o(data_in), .busy_o(busy));
    initial begin
        forever #(CLK_PERIOD_NS / 2) clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    task automatic produce(input logic [DATA_W-1:0] b, input int n, input logic g);
        @(posedge clk_sys_i);
        base <= b;
        num <= 16'(n);
        gap <= g;
        go <= 1'b1;
        @(posedge clk_sys_i);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 5000 && busy; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask : produce
    task automatic rd(input int n, input logic [DATA_W-1:0] first, input logic [DATA_W-1:0] step, input logic oa);
        @(posedge clk_sys_i);
        read_en_n <= 1'b0;
        oa_n <= oa;
        for (int j = 1; j <= n; j++) begin
            @(posedge clk_sys_i);
            read_en_n <= (j == n);
            oa_n <= oa | (j == n);
            #1;
            chk("data_out", data_out, first + DATA_W'(j - 1) * step);
        end
    endtask : rd
    task automatic init(input logic ft, input logic oa, input logic full);
        @(posedge clk_sys_i);
        if (full) full_init_n <= 1'b0;
        else soft_init_n <= 1'b0;
        mode_sel <= ft;
        oa_n <= oa;
        repeat (2) @(posedge clk_sys_i);
        full_init_n <= 1'b1;
        soft_init_n <= 1'b1;
        mode_sel <= 1'b0;
        oa_n <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk("init flags", 18'(flags), 18'({ft, !ft, 3'b101}));
    endtask : init
    task automatic t_normal;
        init(1'b0, 1'b1, 1'b1);
        rd(2, 18'd127, 18'h0, 1'b0);
        produce(18'h100, 3, 1'b0);
        chk("no early word", data_out, 18'd127);
        rd(3, 18'h100, 18'h1, 1'b1);
        // read of an empty store leaves the last word standing
        rd(1, 18'h102, 18'h0, 1'b1);
        chk("empty", 18'(flags[4]), 18'h0);
    endtask : t_normal
    task automatic t_fill;
        int nums[8] = '{126, 1, 897, 1, 896, 1, 126, 3};
        logic [4:0] exp[8] = '{5'b11101, 5'b11111, 5'b11111, 5'b11011, 5'b11011, 5'b11010, 5'b10010, 5'b10010};
        int b = 0;
        for (int k = 0; k < 8; k++) begin
            produce(18'(b), nums[k], 1'b0);
            b += nums[k];
            chk("fill flags", 18'(flags), 18'(exp[k]));
        end
        rd((1 << AW) + 2, 18'h0, 18'h1, 1'b1);
        chk("drained", 18'(flags), 18'(5'b01101));
    endtask : t_fill
    task automatic t_soft;
        @(posedge clk_sys_i);
        oa_n <= 1'b0;
        produce(18'd5, 2, 1'b1);
        @(posedge clk_sys_i);
        oa_n <= 1'b1;
        rd(2, 18'd5, 18'h1, 1'b0);
        produce(18'h0, 3, 1'b1);
        init(1'b0, 1'b1, 1'b0);
        rd(2, 18'd5, 18'h1, 1'b0);
        produce(18'h0, 4, 1'b0);
        chk("four words", 18'(flags), 18'(5'b11101));
        produce(18'h4, 1, 1'b0);
        chk("five words", 18'(flags), 18'(5'b11111));
        rd(2, 18'h0, 18'h1, 1'b1);
        @(posedge clk_sys_i);
        replay_n <= 1'b0;
        @(posedge clk_sys_i);
        replay_n <= 1'b1;
        #1;
        chk("replay empty", 18'(flags[4]), 18'h0);
        rd(3, 18'h0, 18'h1, 1'b1);
    endtask : t_soft
    task automatic t_fall;
        logic [2*AW-1:0] chain = {11'd300, 11'd310};
        init(1'b1, 1'b0, 1'b1);
        rd(2, 18'd1023, 18'h0, 1'b0);
        for (int i = 2 * AW - 1; i >= 0; i--) begin
            @(posedge clk_sys_i);
            oa_n <= 1'b0;
            ser_n <= 1'b0;
            mode_sel <= chain[i];
        end
        @(posedge clk_sys_i);
        oa_n <= 1'b1;
        ser_n <= 1'b1;
        rd(2, 18'd300, 18'd10, 1'b0);
        produce(18'h2aa, 1, 1'b0);
        for (int i = 0; i < 8 && flags[4]; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk("fall word", data_out, 18'h2aa);
        chk("fall flags", 18'(flags[4:3]), 18'h0);
        produce(18'h2ab, 1, 1'b0);
        chk("held word", data_out, 18'h2aa);
        rd(1, 18'h2ab, 18'h0, 1'b1);
        @(posedge clk_sys_i);
        out_en_n <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk("oe", 18'(oe), 18'h1);
        repeat (6) @(posedge clk_sys_i);
        #1;
        chk("power down", 18'(pd), 18'h1);
        @(posedge clk_sys_i);
        out_en_n <= 1'b1;
    endtask : t_fall
    initial begin
        repeat (11) @(posedge clk_sys_i);
        #1;
        chk("reset flags", 18'({flags, oe}), 18'(6'b011010));
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_normal();
        t_fill();
        t_soft();
        t_fall();
        end_of_test();
    end
    // the longest test is the fill and drain, about 4200 cycles
    initial begin
        #(CLK_PERIOD_NS * 40000);
        miscompares++;
        end_of_test();
    end
endmodule : dcfpf_top_bench

// ---- logic/dcfpf_pkg.sv ----
package dcfpf_pkg;

    // word and depth
    localparam int DATA_W         = 18;
    localparam int DEPTH_LOG2_DEF = 17;

    // default offsets chosen at full init
    localparam int OFF_DEF_SHORT  = 127;
    localparam int OFF_DEF_LONG   = 1023;

    // fall-through latency: read-clock transitions, two per cycle
    localparam int FALL_TRANSITIONS = 3;
    localparam int FALL_CYCLES      = (FALL_TRANSITIONS + 1) / 2;
    localparam int FALL_W           = 2;

    // clock rate
    localparam int CLK_PERIOD_NS    = 10;

    // two-entry skid buffer
    localparam logic [1:0] SKID_EMPTY = 2'h0;
    localparam logic [1:0] SKID_ONE   = 2'h1;
    localparam logic [1:0] SKID_FULL  = 2'h2;

endpackage : dcfpf_pkg

// ---- logic/dcfpf_skid2.sv ----
`timescale 1ns/1ps
module dcfpf_skid2
    import dcfpf_pkg::*;
#(
    parameter int W = DATA_W
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic         flush_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    typedef struct packed {
        logic [W-1:0] d0;
        logic [W-1:0] d1;
        logic [1:0]   n;
    } dcfpf_skid_t;

    dcfpf_skid_t s_r;
    dcfpf_skid_t s_nxt;
    logic        take;
    logic        give;
    logic [1:0]  slot;

    always_comb begin
        s_nxt = s_r;
        take  = in_valid_i && (s_r.n != SKID_FULL);
        give  = out_ready_i && (s_r.n != SKID_EMPTY);
        slot  = s_r.n;
        if (give) begin
            s_nxt.d0 = s_r.d1;
            slot     = s_r.n - SKID_ONE;
        end
        if (take) begin
            if (slot == SKID_EMPTY) begin
                s_nxt.d0 = in_data_i;
            end else begin
                s_nxt.d1 = in_data_i;
            end
        end
        s_nxt.n = slot + (take ? SKID_ONE : SKID_EMPTY);
        // flush drops held words, as init discards stored data
        if (flush_i) begin
            s_nxt.n = SKID_EMPTY;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign in_ready_o  = (s_r.n != SKID_FULL);
    assign out_valid_o = (s_r.n != SKID_EMPTY);
    assign out_data_o  = s_r.d0;

endmodule : dcfpf_skid2

// ---- logic/dcfpf_top.sv ----
`timescale 1ns/1ps
// Behaviour
// - stores 18-bit words, 2^17 or 2^18 deep
// - enabled write edge captures input word
// - enabled read edge advances next word out
// - any clock rate, no ratio limits
// - normal mode: first word needs explicit read
// - fall-through: first word appears without read
// - read mode latched from pin at init
// - shared flags: empty/full or valid/room
// - both thresholds independently settable
// - default offsets 127 or 1023
// - serial load shifts one bit per edge
// - parallel load takes offset from data in
// - offset readback on data out
// - full init zeroes both pointers
// - init pin picks 127/parallel or 1023/serial
// - flags follow new mode after full init
// - soft init clears pointers, keeps settings
// - flags recomputed after soft init
// - replay rewinds read pointer to start
// - idle power-down, wakes on write, read, serial load, replay or init
// - output enable gates data drivers; here data_out_o is never gated, only registered onto data_out_oe_o
// - almost-full low above capacity minus offset
// - almost-empty low below empty offset
// - half flag marks above half capacity
// - replay forces empty, keeps write side
module dcfpf_top
    import dcfpf_pkg::*;
#(
    parameter int DEPTH_LOG2 = DEPTH_LOG2_DEF
) (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    // init and replay controls
    input  wire logic              full_init_n_i,
    input  wire logic              soft_init_n_i,
    input  wire logic              replay_n_i,
    // mode select and offset access
    input  wire logic              mode_sel_serial_in_i,
    input  wire logic              offset_access_n_i,
    input  wire logic              ser_load_en_n_i,
    // write port
    input  wire logic              write_en_n_i,
    input  wire logic [DATA_W-1:0] data_in_i,
    // read port
    input  wire logic              read_en_n_i,
    input  wire logic              out_en_n_i,
    output logic [DATA_W-1:0]      data_out_o,
    output logic                   data_out_oe_o,
    // flags, active low
    output logic                   empty_n_o,
    output logic                   full_n_o,
    output logic                   half_n_o,
    output logic                   almost_empty_n_o,
    output logic                   almost_full_n_o,
    // power state
    output logic                   power_down_o
);

    localparam int AW = DEPTH_LOG2;
    localparam int CW = DEPTH_LOG2 + 1;
    localparam logic [CW-1:0] CAP      = {1'b1, {AW{1'b0}}};
    localparam logic [CW-1:0] HALF     = {2'b01, {(AW-1){1'b0}}};
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE  = {{AW{1'b0}}, 1'b1};
    localparam logic [AW-1:0] PTR_ONE  = {{(AW-1){1'b0}}, 1'b1};
    localparam logic [AW-1:0] OFF_S    = AW'(OFF_DEF_SHORT);
    localparam logic [AW-1:0] OFF_L    = AW'(OFF_DEF_LONG);
    localparam logic [FALL_W-1:0] FALL_LAST = FALL_W'(FALL_CYCLES - 1);
    localparam logic [FALL_W-1:0] FALL_ONE  = {{(FALL_W-1){1'b0}}, 1'b1};

    typedef struct packed {
        logic              fall_through_mode;
        logic              serial;
        logic [AW-1:0]     wptr;
        logic [AW-1:0]     rptr;
        logic [CW-1:0]     cnt;
        logic [AW-1:0]     e_off;
        logic [AW-1:0]     f_off;
        logic              wsel;
        logic              rsel;
        logic [FALL_W-1:0] fall;
        logic              ovalid;
        logic [DATA_W-1:0] dout;
        logic              oe;
        logic              ef;
        logic              ff;
        logic              hf;
        logic              ae;
        logic              af;
        logic              pd;
    } dcfpf_state_t;

    dcfpf_state_t      s_r;
    dcfpf_state_t      s_nxt;
    logic [DATA_W-1:0] mem [0:(1<<AW)-1];
    logic [DATA_W-1:0] mem_rd;
    logic              init_full;
    logic              init_soft;
    logic              buf_in_valid;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic              buf_out_ready;
    logic [DATA_W-1:0] buf_out_data;
    logic              mem_push;
    logic              pop;
    logic              rd_req;
    logic              off_rd;
    logic              replay;

    // producer word lands in the skid first, so up to two words written while full are held; a third is lost
    assign buf_in_valid  = !write_en_n_i && offset_access_n_i;
    assign init_full     = !full_init_n_i;
    assign init_soft     = !soft_init_n_i;
    assign buf_out_ready = (s_r.cnt != CAP) && !init_full && !init_soft;
    assign mem_push      = buf_out_valid && buf_out_ready;
    assign mem_rd        = mem[s_r.rptr];

    dcfpf_skid2 #(
        .W (DATA_W)
    ) u_skid (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (init_full || init_soft),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (data_in_i),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_out_ready),
        .out_data_o  (buf_out_data)
    );

    always_comb begin
        s_nxt  = s_r;
        pop    = 1'b0;
        rd_req = !read_en_n_i && offset_access_n_i;
        off_rd = !read_en_n_i && !offset_access_n_i;
        replay = !replay_n_i;

        // offset programming on the write side
        if (!s_r.serial && !write_en_n_i && !offset_access_n_i) begin
            if (!s_r.wsel) begin
                s_nxt.e_off = data_in_i[AW-1:0];
            end else begin
                s_nxt.f_off = data_in_i[AW-1:0];
            end
            s_nxt.wsel = !s_r.wsel;
        end
        // serial chain: empty offset msb first, then full offset
        if (s_r.serial && !ser_load_en_n_i && !offset_access_n_i) begin
            {s_nxt.e_off, s_nxt.f_off} = {s_r.e_off[AW-2:0], s_r.f_off, mode_sel_serial_in_i};
        end

        // read side
        if (off_rd) begin
            s_nxt.dout = DATA_W'(s_r.rsel ? s_r.f_off : s_r.e_off);
            s_nxt.rsel = !s_r.rsel;
        end else if (!s_r.fall_through_mode) begin
            if (rd_req && (s_r.cnt != CNT_ZERO)) begin
                pop        = 1'b1;
                s_nxt.dout = mem_rd;
            end
        end else begin
            if (s_r.ovalid) begin
                // later words only move on an enabled read
                if (rd_req) begin
                    if (s_r.cnt != CNT_ZERO) begin
                        pop        = 1'b1;
                        s_nxt.dout = mem_rd;
                    end else begin
                        s_nxt.ovalid = 1'b0;
                    end
                end
            end else if (s_r.cnt != CNT_ZERO) begin
                // first word falls through after a fixed delay
                if (s_r.fall == FALL_LAST) begin
                    pop          = 1'b1;
                    s_nxt.dout   = mem_rd;
                    s_nxt.ovalid = 1'b1;
                    s_nxt.fall   = '0;
                end else begin
                    s_nxt.fall = s_r.fall + FALL_ONE;
                end
            end
        end

        // pointers and count; both sides share one clock so the count is exact
        if (mem_push) begin
            s_nxt.wptr = s_r.wptr + PTR_ONE;
        end
        if (replay) begin
            pop          = 1'b0;
            s_nxt.rptr   = '0;
            s_nxt.ovalid = 1'b0;
            s_nxt.fall   = '0;
            s_nxt.cnt    = ((s_r.cnt == CAP) ? CAP : {1'b0, s_r.wptr}) + (mem_push ? CNT_ONE : CNT_ZERO);
        end else begin
            s_nxt.rptr = s_r.rptr + (pop ? PTR_ONE : '0);
            s_nxt.cnt  = s_r.cnt + (mem_push ? CNT_ONE : CNT_ZERO) - (pop ? CNT_ONE : CNT_ZERO);
        end

        // soft init keeps mode, method and offsets
        if (init_soft) begin
            s_nxt.wptr   = '0;
            s_nxt.rptr   = '0;
            s_nxt.cnt    = '0;
            s_nxt.ovalid = 1'b0;
            s_nxt.fall   = '0;
            s_nxt.dout   = '0;
            s_nxt.wsel   = 1'b0;
            s_nxt.rsel   = 1'b0;
        end
        // full init latches straps while held low
        if (init_full) begin
            s_nxt.wptr   = '0;
            s_nxt.rptr   = '0;
            s_nxt.cnt    = '0;
            s_nxt.ovalid = 1'b0;
            s_nxt.fall   = '0;
            s_nxt.dout   = '0;
            s_nxt.wsel   = 1'b0;
            s_nxt.rsel   = 1'b0;
            s_nxt.fall_through_mode   = mode_sel_serial_in_i;
            s_nxt.serial = !offset_access_n_i;
            s_nxt.e_off  = offset_access_n_i ? OFF_S : OFF_L;
            s_nxt.f_off  = offset_access_n_i ? OFF_S : OFF_L;
        end

        // flags from next state, so they follow any init at once
        s_nxt.ef = s_nxt.fall_through_mode ? !s_nxt.ovalid : (s_nxt.cnt != CNT_ZERO);
        if (replay && !s_nxt.fall_through_mode) begin
            s_nxt.ef = 1'b0;
        end
        s_nxt.ff = s_nxt.fall_through_mode ? (s_nxt.cnt == CAP) : (s_nxt.cnt != CAP);
        s_nxt.hf = !(s_nxt.cnt > HALF);
        s_nxt.ae = !(s_nxt.cnt < {1'b0, s_nxt.e_off});
        s_nxt.af = !(s_nxt.cnt > (CAP - {1'b0, s_nxt.f_off}));
        s_nxt.oe = !out_en_n_i;

        // idle when write, read, serial load, replay and both inits are inactive and no word enters the store; any of them wakes it next edge
        s_nxt.pd = write_en_n_i && read_en_n_i && ser_load_en_n_i && replay_n_i
                   && full_init_n_i && soft_init_n_i && !mem_push;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_r        <= '0;
            s_r.e_off  <= OFF_S;
            s_r.f_off  <= OFF_S;
            s_r.hf     <= 1'b1;
            s_r.ae     <= 1'b0;
            s_r.af     <= 1'b1;
            s_r.ff     <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // storage array kept out of the state record
    always_ff @(posedge clk_sys_i) begin
        if (mem_push) begin
            mem[s_r.wptr] <= buf_out_data;
        end
    end

    assign data_out_o       = s_r.dout;
    assign data_out_oe_o    = s_r.oe;
    assign empty_n_o        = s_r.ef;
    assign full_n_o         = s_r.ff;
    assign half_n_o         = s_r.hf;
    assign almost_empty_n_o = s_r.ae;
    assign almost_full_n_o  = s_r.af;
    assign power_down_o     = s_r.pd;

    // buffer ready is only advisory here; the full flag is the producer's gate
    logic unused_ready;
    assign unused_ready = buf_in_ready;

endmodule : dcfpf_top
